// File: logic/hpp_cfg.svh
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH

// ============================================================
// Device register map (byte addresses on the 10-bit bus)
`define HPP_MR_ADDR     10'h000
`define HPP_IR_ADDR     10'h002
`define HPP_IMR_ADDR    10'h004
`define HPP_PCFG_BASE   10'h008
`define HPP_PDPT_BASE   10'h010
`define HPP_PIN_STRIDE  10'h002

// ============================================================
// Field positions and reset values
`define HPP_BW_BIT      15
`define HPP_WDF_HI      13
`define HPP_WDF_LO      11
`define HPP_POL_BIT     7
`define HPP_TYPE_BIT    6
`define HPP_SOCK_HI     2
`define HPP_MR_RST      16'h0000
`define HPP_IMR_RST     16'h0000
`define HPP_PCFG_RST    16'h0000
`define HPP_PDPT_RST    16'h0000
`define HPP_EV_BITS     5
`define HPP_IDLE_PINS   16'hffff

// ============================================================
// Host controller register map (3-bit word index)
`define HPP_H_ADDR      3'h0
`define HPP_H_WDATA     3'h1
`define HPP_H_CTRL      3'h2
`define HPP_H_STATUS    3'h3
`define HPP_H_RDATA     3'h4
`define HPP_H_ISTS      3'h5
`define HPP_H_IMASK     3'h6
`define HPP_CTRL_WR     0
`define HPP_CTRL_RD     1
`define HPP_CTRL_RST    2
`define HPP_ST_BUSY     0
`define HPP_ST_INT      1
`define HPP_IS_DONE     0
`define HPP_IS_DEVINT   1

// ============================================================
// Timing
`define HPP_MCLK_NS     100
`define HPP_RST_LOW_NS  2000
`define HPP_PLL_WAIT_NS 10000000
`define HPP_STROBE_CYC  12
`define HPP_GAP_CYC     3

`endif

// File: logic/hpp_device.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module hpp_device #(
    parameter int unsigned NUM_SOCK = 8,
    parameter int unsigned NUM_PINS = 4
) (
    input  wire logic                     mclk,
    input  wire logic                     reset,
    input  wire logic                     ce,
    input  wire logic [`HPP_EV_BITS-1:0]  sock_event,
    input  wire logic [NUM_SOCK*16-1:0]   tx_free_size,
    input  wire logic [NUM_SOCK*16-1:0]   rx_recv_size,
    output      logic                     bus_width_flag,
    hpp_if.device                         bus
);
    initial begin
        if (NUM_SOCK < 1 || NUM_SOCK > 8 || NUM_PINS != 4)
            $error("hpp_device: unsupported socket or pin count");
    end

    localparam int SW = 30;

    logic [SW:0]  pin_s1;
    logic [SW:0]  pin_s2;
    logic         rst_n_s;
    logic         strap_s;
    logic         cs_n_s;
    logic         wr_n_s;
    logic         rd_n_s;
    logic [9:0]   addr_s;
    logic [15:0]  data_s;
    logic         rst_i;
    logic         wr_act;
    logic         wr_act_d;
    logic         wr_pend;
    logic [2:0]   wr_cnt;
    logic         wr_do;
    logic [9:0]   wr_idx;
    logic [15:0]  wr_val;
    logic [15:0]  wr_lane;
    logic         rd_act;
    logic [15:0]  rd_word;
    logic [15:0]  mode_reg;
    logic [`HPP_EV_BITS-1:0] ev_flags;
    logic [`HPP_EV_BITS-1:0] ev_mask;
    logic [15:0]  pin_cfg [NUM_PINS];
    logic [15:0]  pin_dpt [NUM_PINS];

    // ============================================================
    // Input synchronisers: strobes, address, data, strap and reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_s1 <= {1'b0, 1'b0, 3'b111, 10'h000, 16'h0000};
            pin_s2 <= {1'b0, 1'b0, 3'b111, 10'h000, 16'h0000};
        end else if (ce) begin
            pin_s1 <= {bus.reset_n, bus.bus_width_select, bus.cs_n,
                       bus.wr_n, bus.rd_n, bus.addr, bus.data};
            pin_s2 <= pin_s1;
        end
    end
    assign {rst_n_s, strap_s, cs_n_s, wr_n_s, rd_n_s, addr_s, data_s}
        = pin_s2;

    // Pin reset and local reset both hold the port behind the synchronisers; pin reset loads the strap flag
    assign rst_i = reset || !rst_n_s;

    // ============================================================
    // Bus width strap
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus_width_flag <= 1'b0;
        end else if (ce && rst_i) begin
            bus_width_flag <= strap_s;
        end
        // Strap changes outside reset are ignored
    end

    // ============================================================
    // Write capture with programmable fetch delay
    assign wr_act = !cs_n_s && !wr_n_s;
    assign wr_do  = wr_pend && (wr_cnt == mode_reg[`HPP_WDF_HI:`HPP_WDF_LO]
                                || !wr_act);
    assign wr_idx = {addr_s[9:1], 1'b0};

    always_ff @(posedge mclk) begin
        if (rst_i) begin
            wr_act_d <= 1'b0;
            wr_pend  <= 1'b0;
            wr_cnt   <= 3'b000;
        end else if (ce) begin
            wr_act_d <= wr_act;
            if (wr_act && !wr_act_d) begin
                wr_pend <= 1'b1;
                wr_cnt  <= 3'b000;
            end else if (wr_do) begin
                wr_pend <= 1'b0;
            end else if (wr_pend) begin
                wr_cnt <= wr_cnt + 3'b001;
            end
        end
    end

    // Byte writes land in one lane; the other lane keeps its value
    always_comb begin
        if (bus_width_flag) begin
            wr_val  = data_s;
            wr_lane = 16'hffff;
        end else if (!addr_s[0]) begin
            wr_val  = {data_s[7:0], 8'h00};
            wr_lane = 16'hff00;
        end else begin
            wr_val  = {8'h00, data_s[7:0]};
            wr_lane = 16'h00ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_i) begin
            mode_reg <= `HPP_MR_RST;
            ev_mask  <= `HPP_EV_BITS'(`HPP_IMR_RST);
        end else if (ce && wr_do) begin
            if (wr_idx == `HPP_MR_ADDR)
                mode_reg <= (mode_reg & ~wr_lane) | (wr_val & wr_lane);
            if (wr_idx == `HPP_IMR_ADDR)
                ev_mask <= `HPP_EV_BITS'((16'(ev_mask) & ~wr_lane)
                                         | (wr_val & wr_lane));
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin_regs
            localparam logic [9:0] CFG_A =
                `HPP_PCFG_BASE + 10'(gp) * `HPP_PIN_STRIDE;
            localparam logic [9:0] DPT_A =
                `HPP_PDPT_BASE + 10'(gp) * `HPP_PIN_STRIDE;
            always_ff @(posedge mclk) begin
                if (rst_i) begin
                    pin_cfg[gp] <= `HPP_PCFG_RST;
                    pin_dpt[gp] <= `HPP_PDPT_RST;
                end else if (ce && wr_do) begin
                    if (wr_idx == CFG_A)
                        pin_cfg[gp] <= (pin_cfg[gp] & ~wr_lane)
                                       | (wr_val & wr_lane);
                    if (wr_idx == DPT_A)
                        pin_dpt[gp] <= (pin_dpt[gp] & ~wr_lane)
                                       | (wr_val & wr_lane);
                end
            end
        end
    endgenerate

    // ============================================================
    // Event flags and interrupt pin
    always_ff @(posedge mclk) begin
        if (rst_i) begin
            ev_flags <= '0;
        end else if (ce) begin
            // A new event beats a simultaneous clear
            ev_flags <= (ev_flags & ~((wr_do && wr_idx == `HPP_IR_ADDR)
                        ? `HPP_EV_BITS'(wr_val & wr_lane)
                        : `HPP_EV_BITS'(0))) | sock_event;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_i) begin
            bus.int_n <= 1'b1;
        end else if (ce) begin
            bus.int_n <= ~|(ev_flags & ev_mask);
        end
    end

    // ============================================================
    // Read path
    assign rd_act = !cs_n_s && !rd_n_s;

    always_comb begin
        rd_word = 16'h0000;
        case (wr_idx)
            `HPP_MR_ADDR:  rd_word = {bus_width_flag,
                                      mode_reg[`HPP_BW_BIT-1:0]};
            `HPP_IR_ADDR:  rd_word = 16'(ev_flags);
            `HPP_IMR_ADDR: rd_word = 16'(ev_mask);
            default: begin
                for (int i = 0; i < NUM_PINS; i++) begin
                    if (wr_idx == `HPP_PCFG_BASE
                        + 10'(i) * `HPP_PIN_STRIDE)
                        rd_word = pin_cfg[i];
                    if (wr_idx == `HPP_PDPT_BASE
                        + 10'(i) * `HPP_PIN_STRIDE)
                        rd_word = pin_dpt[i];
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst_i) begin
            bus.dev_dout  <= 16'h0000;
            bus.dev_oe_lo <= 1'b0;
            bus.dev_oe_hi <= 1'b0;
        end else if (ce) begin
            bus.dev_oe_lo <= rd_act;
            bus.dev_oe_hi <= rd_act && bus_width_flag;
            if (bus_width_flag)
                bus.dev_dout <= rd_word;
            else
                bus.dev_dout <= {8'h00, addr_s[0] ? rd_word[7:0]
                                                  : rd_word[15:8]};
        end
    end

    // ============================================================
    // Buffer ready pins
    genvar gb;
    generate
        for (gb = 0; gb < NUM_PINS; gb++) begin : g_ready
            logic [2:0]  sock;
            logic [15:0] size;
            assign sock = pin_cfg[gb][`HPP_SOCK_HI:0];
            // Out-of-range socket numbers compare against zero size
            assign size = (32'(sock) >= NUM_SOCK) ? 16'h0000
                        : pin_cfg[gb][`HPP_TYPE_BIT]
                          ? tx_free_size[32'(sock)*16 +: 16]
                          : rx_recv_size[32'(sock)*16 +: 16];
            always_ff @(posedge mclk) begin
                if (rst_i) begin
                    bus.buffer_ready_out[gb] <= 1'b0;
                end else if (ce) begin
                    bus.buffer_ready_out[gb] <= (size >= pin_dpt[gb])
                        ~^ pin_cfg[gb][`HPP_POL_BIT];
                end
            end
        end
    endgenerate
endmodule : hpp_device

// File: logic/hpp_host.sv
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module hpp_host #(
    parameter bit          BUS16        = 1'b1,
    parameter int unsigned RST_LOW_CYC  =
        (`HPP_RST_LOW_NS + `HPP_MCLK_NS - 1) / `HPP_MCLK_NS,
    parameter int unsigned PLL_WAIT_CYC =
        (`HPP_PLL_WAIT_NS + `HPP_MCLK_NS - 1) / `HPP_MCLK_NS
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [15:0] reg_rdata,
    output      logic        irq,
    hpp_if.host              bus
);
    initial begin
        if (RST_LOW_CYC < 1 || PLL_WAIT_CYC < 1 ||
            RST_LOW_CYC >= (1 << 24) || PLL_WAIT_CYC >= (1 << 24))
            $error("hpp_host: timing counts out of range");
    end

    localparam logic [23:0] RLOW_END = 24'(RST_LOW_CYC - 1);
    localparam logic [23:0] RWAIT_END = 24'(PLL_WAIT_CYC - 1);
    localparam logic [23:0] STB_END = 24'(`HPP_STROBE_CYC - 1);
    localparam logic [23:0] GAP_END = 24'(`HPP_GAP_CYC - 1);

    hpp_pkg::hpp_hstate_t state;
    logic [23:0] cnt;
    logic [9:0]  acc_addr;
    logic [15:0] acc_wdata;
    logic [15:0] acc_rdata;
    logic        acc_is_rd;
    logic [1:0]  ists;
    logic [1:0]  imask;
    logic [16:0] in_s1;
    logic [16:0] in_s2;
    logic        done_ev;
    logic        dev_int;
    logic        go_rst;
    logic        go_acc;

    // ============================================================
    // Pin inputs synchroniser
    always_ff @(posedge mclk) begin
        if (reset) begin
            in_s1 <= {1'b1, `HPP_IDLE_PINS};
            in_s2 <= {1'b1, `HPP_IDLE_PINS};
        end else if (ce) begin
            in_s1 <= {bus.int_n, bus.data};
            in_s2 <= in_s1;
        end
    end
    assign dev_int = ~in_s2[16];

    assign go_rst = reg_wr && reg_addr == `HPP_H_ADDR + 3'h2
                    && reg_wdata[`HPP_CTRL_RST];
    assign go_acc = reg_wr && reg_addr == `HPP_H_CTRL
                    && (reg_wdata[`HPP_CTRL_WR] || reg_wdata[`HPP_CTRL_RD]);
    assign done_ev = state == hpp_pkg::HPP_H_GAP && cnt == GAP_END;

    // ============================================================
    // Sequencer: reset pulse, PLL wait, strobed accesses
    always_ff @(posedge mclk) begin
        if (reset) begin
            state     <= hpp_pkg::HPP_H_RLOW;
            cnt       <= 24'h0000;
            acc_is_rd <= 1'b0;
            acc_rdata <= 16'h0000;
        end else if (ce) begin
            cnt <= cnt + 24'h0001;
            case (state)
                hpp_pkg::HPP_H_IDLE: begin
                    cnt <= 24'h0000;
                    if (go_rst) begin
                        state <= hpp_pkg::HPP_H_RLOW;
                    end else if (go_acc) begin
                        state     <= hpp_pkg::HPP_H_ACC;
                        acc_is_rd <= reg_wdata[`HPP_CTRL_RD];
                    end
                end
                hpp_pkg::HPP_H_RLOW: begin
                    if (cnt == RLOW_END) begin
                        state <= hpp_pkg::HPP_H_RWAIT;
                        cnt   <= 24'h0000;
                    end
                end
                hpp_pkg::HPP_H_RWAIT: begin
                    if (cnt == RWAIT_END) begin
                        state <= hpp_pkg::HPP_H_IDLE;
                        cnt   <= 24'h0000;
                    end
                end
                hpp_pkg::HPP_H_ACC: begin
                    if (cnt == STB_END) begin
                        state <= hpp_pkg::HPP_H_GAP;
                        cnt   <= 24'h0000;
                        if (acc_is_rd)
                            acc_rdata <= BUS16 ? in_s2[15:0]
                                               : {8'h00, in_s2[7:0]};
                    end
                end
                hpp_pkg::HPP_H_GAP: begin
                    if (done_ev) begin
                        state <= hpp_pkg::HPP_H_IDLE;
                        cnt   <= 24'h0000;
                    end
                end
                default: begin
                    state <= hpp_pkg::HPP_H_IDLE;
                    cnt   <= 24'h0000;
                end
            endcase
        end
    end

    // ============================================================
    // Pin drivers, all from flops
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus.reset_n          <= 1'b0;
            bus.bus_width_select <= 1'b0;
            bus.cs_n             <= 1'b1;
            bus.wr_n             <= 1'b1;
            bus.rd_n             <= 1'b1;
            bus.addr             <= 10'h000;
            bus.host_dout        <= 16'h0000;
            bus.host_oe          <= 1'b0;
        end else if (ce) begin
            bus.bus_width_select <= BUS16;
            bus.reset_n <= state != hpp_pkg::HPP_H_RLOW
                           && !(state == hpp_pkg::HPP_H_IDLE && go_rst);
            bus.cs_n    <= state != hpp_pkg::HPP_H_ACC;
            bus.wr_n    <= !(state == hpp_pkg::HPP_H_ACC && !acc_is_rd);
            bus.rd_n    <= !(state == hpp_pkg::HPP_H_ACC && acc_is_rd);
            bus.host_oe <= state == hpp_pkg::HPP_H_ACC && !acc_is_rd;
            bus.addr    <= acc_addr;
            bus.host_dout <= acc_wdata;
        end
    end

    // ============================================================
    // Command registers and interrupt
    always_ff @(posedge mclk) begin
        if (reset) begin
            acc_addr  <= 10'h000;
            acc_wdata <= 16'h0000;
            imask     <= 2'b00;
        end else if (ce && reg_wr && state == hpp_pkg::HPP_H_IDLE) begin
            if (reg_addr == `HPP_H_ADDR)
                acc_addr <= reg_wdata[9:0];
            if (reg_addr == `HPP_H_WDATA)
                acc_wdata <= reg_wdata;
        end else if (ce && reg_wr && reg_addr == `HPP_H_IMASK) begin
            imask <= reg_wdata[1:0];
        end
        if (!reset && ce && reg_wr && reg_addr == `HPP_H_IMASK
            && state == hpp_pkg::HPP_H_IDLE)
            imask <= reg_wdata[1:0];
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ists <= 2'b00;
        end else if (ce) begin
            // Set wins over a write-one clear in the same cycle
            ists <= (ists & ~((reg_wr && reg_addr == `HPP_H_ISTS)
                              ? reg_wdata[1:0] : 2'b00))
                    | {dev_int, done_ev};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq       <= 1'b0;
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            irq <= |(ists & imask);
            if (reg_rd) begin
                case (reg_addr)
                    `HPP_H_ADDR:   reg_rdata <= {6'h00, acc_addr};
                    `HPP_H_WDATA:  reg_rdata <= acc_wdata;
                    `HPP_H_STATUS: reg_rdata <= {14'h0000, dev_int,
                                       state != hpp_pkg::HPP_H_IDLE};
                    `HPP_H_RDATA:  reg_rdata <= acc_rdata;
                    `HPP_H_ISTS:   reg_rdata <= {14'h0000, ists};
                    `HPP_H_IMASK:  reg_rdata <= {14'h0000, imask};
                    default:       reg_rdata <= 16'h0000;
                endcase
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end
endmodule : hpp_host

// File: logic/hpp_if.sv
`timescale 1ns/1ps
`include "hpp_cfg.svh"
interface hpp_if;
    logic        reset_n;
    logic        bus_width_select;
    logic        cs_n;
    logic        wr_n;
    logic        rd_n;
    logic [9:0]  addr;
    logic [15:0] host_dout;
    logic        host_oe;
    logic [15:0] dev_dout;
    logic        dev_oe_lo;
    logic        dev_oe_hi;
    logic        int_n;
    logic [3:0]  buffer_ready_out;
    logic [15:0] data;

    // Resolved data lines; undriven lines float high
    always_comb begin
        data = `HPP_IDLE_PINS;
        if (host_oe)
            data = host_dout;
        if (dev_oe_lo)
            data[7:0] = dev_dout[7:0];
        if (dev_oe_hi)
            data[15:8] = dev_dout[15:8];
    end

    modport device (
        input  reset_n, bus_width_select, cs_n, wr_n, rd_n, addr, data,
        output dev_dout, dev_oe_lo, dev_oe_hi, int_n, buffer_ready_out
    );
    modport host (
        output reset_n, bus_width_select, cs_n, wr_n, rd_n, addr,
        output host_dout, host_oe,
        input  data, int_n, buffer_ready_out
    );
endinterface : hpp_if

// File: logic/hpp_pkg.sv
package hpp_pkg;
    typedef enum logic [2:0] {
        HPP_H_IDLE  = 3'b000,
        HPP_H_RLOW  = 3'b001,
        HPP_H_RWAIT = 3'b010,
        HPP_H_ACC   = 3'b011,
        HPP_H_GAP   = 3'b100
    } hpp_hstate_t;

    typedef logic [15:0] hpp_word_t;
endpackage : hpp_pkg

// File: tb/host_parallel_bus_port_test.sv
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module host_parallel_bus_port_test;
    logic        mclk, reset, ce, reg_wr, reg_rd, irq, bw_flag;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, r, d, sz, cfg, alt;
    logic [4:0]  sock_event;
    logic [31:0] tx_sz, rx_sz, tv, rv, seed;
    int          err_total, tests_run, cyc;
    hpp_if bus_if();
    hpp_host #(.BUS16(1'b1), .RST_LOW_CYC(3), .PLL_WAIT_CYC(50)) hpp_host_inst (
        .mclk, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .bus(bus_if.host));
    hpp_device #(.NUM_SOCK(2)) hpp_device_inst (
        .mclk, .reset, .ce, .sock_event, .tx_free_size(tx_sz),
        .rx_recv_size(rx_sz), .bus_width_flag(bw_flag), .bus(bus_if.device));
    hpp_monitor hpp_monitor_inst (
        .mclk, .reset, .reset_n(bus_if.reset_n),
        .bus_width_select(bus_if.bus_width_select), .cs_n(bus_if.cs_n),
        .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .addr(bus_if.addr),
        .dev_oe_lo(bus_if.dev_oe_lo), .dev_oe_hi(bus_if.dev_oe_hi),
        .int_n(bus_if.int_n));
    // ============================================================
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Expected pin level: active level only while size reaches depth
    function automatic logic rdy(logic [15:0] s, logic [15:0] p, logic pol);
        return (s >= p) ~^ pol;
    endfunction : rdy
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask : chk
    // ============================================================
    task automatic wr(logic [2:0] a, logic [15:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [2:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic wait_idle;
        logic [15:0] s;
        s = 16'h0001;
        for (int i = 0; i < 200 && s[0] !== 1'b0; i++)
            rd(`HPP_H_STATUS, s);
        chk("busy", 16'h0000, {15'h0000, s[0]});
    endtask : wait_idle
    task automatic dacc(int b, logic [9:0] a, logic [15:0] v);
        wr(`HPP_H_ADDR, {6'h00, a});
        wr(`HPP_H_WDATA, v);
        wr(`HPP_H_CTRL, 16'h0001 << b);
        wait_idle();
    endtask : dacc
    task automatic devrd(logic [9:0] a, output logic [15:0] v);
        dacc(`HPP_CTRL_RD, a, 16'h0000);
        rd(`HPP_H_RDATA, v);
    endtask : devrd
    task automatic settle(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    // ============================================================
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        {reset, ce, reg_wr, reg_rd, reg_addr} = {2'b11, 5'h00};
        {reg_wdata, sock_event, tx_sz, rx_sz} = '0;
        {err_total, tests_run, cyc} = '0;
        seed = 32'h0001_1577;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        wait_idle();
        devrd(`HPP_MR_ADDR, r);
        chk("bus_width", 16'h0001, {15'h0000, r[`HPP_BW_BIT]});
        chk("width_flag", 16'h0001, {15'h0000, bw_flag});
        seed = lfsr_next(seed);
        dacc(`HPP_CTRL_WR, `HPP_MR_ADDR, seed[15:0] & 16'h3800);
        devrd(`HPP_MR_ADDR, r);
        chk("mode", {12'h000, 1'b1, seed[13:11]},
            {12'h000, r[15], r[13:11]});
        // Odd address must land on the even word in wide mode
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            dacc(`HPP_CTRL_WR, `HPP_IMR_ADDR | 10'h001, seed[15:0]);
            devrd(`HPP_IMR_ADDR, r);
            chk("mask", {11'h000, seed[4:0]}, {11'h000, r[4:0]});
        end
        devrd(10'h3fe, r);
        chk("unmapped", 16'h0000, r);
        // Unselected lanes get the opposite verdict so a wrong pick shows
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            d = seed[15:0] | 16'h0001;
            cfg = {8'h00, i[0] ^ i[1], i[0], 5'h00, i[1]};
            dacc(`HPP_CTRL_WR, `HPP_PCFG_BASE + 10'(2 * i), cfg);
            dacc(`HPP_CTRL_WR, `HPP_PDPT_BASE + 10'(2 * i), d);
            for (int k = 0; k < 2; k++) begin
                sz = d - 16'(k);
                alt = k ? 16'hffff : 16'h0000;
                tv = {2{alt}};
                rv = {2{alt}};
                if (i[0])
                    tv[16 * i[1] +: 16] = sz;
                else
                    rv[16 * i[1] +: 16] = sz;
                @(posedge mclk);
                tx_sz <= tv;
                rx_sz <= rv;
                settle(4);
                chk("ready", {15'h0000, rdy(sz, d, cfg[7])},
                    {15'h0000, bus_if.buffer_ready_out[i]});
            end
        end
        dacc(`HPP_CTRL_WR, `HPP_IMR_ADDR, 16'h001f);
        // An event offered while the clock enable is low must be lost
        @(posedge mclk);
        ce         <= 1'b0;
        sock_event <= 5'h01;
        settle(4);
        chk("frozen_int", 16'h0001, {15'h0000, bus_if.int_n});
        @(posedge mclk);
        ce         <= 1'b1;
        sock_event <= 5'h00;
        wr(`HPP_H_IMASK, 16'h0002);
        for (int e = 0; e < 6; e++) begin
            if (e == 5)
                dacc(`HPP_CTRL_WR, `HPP_IMR_ADDR, 16'h0000);
            @(posedge mclk);
            sock_event <= 5'h01 << (e % 5);
            @(posedge mclk);
            sock_event <= 5'h00;
            settle(8);
            chk("int_n", {15'h0000, e == 5}, {15'h0000, bus_if.int_n});
            chk("irq", {15'h0000, e != 5}, {15'h0000, irq});
            dacc(`HPP_CTRL_WR, `HPP_IR_ADDR, 16'h0001 << (e % 5));
            wr(`HPP_H_ISTS, 16'h0002);
            settle(4);
            chk("int_n_clr", 16'h0001, {15'h0000, bus_if.int_n});
            chk("irq_clr", 16'h0000, {15'h0000, irq});
        end
        // Hard reset recaptures the strap and clears the fetch delay
        wr(`HPP_H_CTRL, 16'h0004);
        wait_idle();
        devrd(`HPP_MR_ADDR, r);
        chk("mode_rst", 16'h8000, r);
        // Completion flag has been pending since the first access
        wr(`HPP_H_IMASK, 16'h0001);
        settle(3);
        chk("done_irq", 16'h0001, {15'h0000, irq});
        wr(`HPP_H_ISTS, 16'h0001);
        settle(3);
        chk("done_clr", 16'h0000, {15'h0000, irq});
        summarize();
    end
endmodule : host_parallel_bus_port_test

// File: tb/hpp_monitor.sv
`timescale 1ns/1ps
module hpp_monitor #(
    parameter int unsigned RST_LOW_CYC  = 3,
    parameter int unsigned PLL_WAIT_CYC = 50
) (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       reset_n,
    input wire logic       bus_width_select,
    input wire logic       cs_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic [9:0] addr,
    input wire logic       dev_oe_lo,
    input wire logic       dev_oe_hi,
    input wire logic       int_n
);
    logic [15:0] lo_cnt;
    logic [15:0] hi_cnt;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // ============================================================
    // Run lengths of the pin reset level, saturating
    always_ff @(posedge mclk) begin
        if (reset || reset_n)
            lo_cnt <= 16'h0000;
        else if (lo_cnt != 16'hffff)
            lo_cnt <= lo_cnt + 16'h0001;
    end
    always_ff @(posedge mclk) begin
        if (!reset_n)
            hi_cnt <= 16'h0000;
        else if (hi_cnt != 16'hffff)
            hi_cnt <= hi_cnt + 16'h0001;
    end
    // ============================================================
    sequence rd_start;
        $fell(rd_n) && !cs_n;
    endsequence
    sequence wr_start;
        $fell(wr_n) && !cs_n;
    endsequence
    hold_reset_a: assert property ($rose(reset_n) |-> lo_cnt >= RST_LOW_CYC)
        else $error("pin reset released too early");
    pll_wait_a: assert property (!cs_n |-> hi_cnt >= PLL_WAIT_CYC)
        else $error("access before settle time");
    reset_int_a: assert property (!reset_n [*4] |-> int_n)
        else $error("interrupt low during pin reset");
    upper_hiz_a: assert property (!bus_width_select |-> !dev_oe_hi)
        else $error("upper byte driven in narrow mode");
    cs_hiz_a: assert property (cs_n [*5] |-> !dev_oe_lo && !dev_oe_hi)
        else $error("data driven while deselected");
    wr_hold_a: assert property (wr_start |-> ##1 ($stable(addr) && !wr_n) [*8])
        else $error("write strobe or address not held");
    rd_drive_a: assert property (rd_start |-> ##[2:4] dev_oe_lo)
        else $error("read data not driven");
    rd_idle_a: assert property (rd_n [*5] |-> !dev_oe_lo && !dev_oe_hi)
        else $error("data driven without read");
endmodule : hpp_monitor
